// >>> hw/rsc_run_stop.v
// run/stop supervisor for the scan engine, with apb register access
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "rsc_consts.vh"

module rsc_run_stop #(
  parameter NCLS = `RSC_MEM_CLASSES
) (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`RSC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire power_ok,
  input wire stop_pin,
  input wire reset_pin,
  input wire keep_valid,
  input wire keep_relay,
  input wire scan_done,
  output reg scan_go,
  output reg running,
  output reg periph_halt,
  output reg outputs_clear,
  output reg timer_reset,
  output reg [NCLS-1:0] mem_clear,
  output reg relay_store
);

  // one-hot sequencer states
  localparam ST_BOOT = 3'b001;
  localparam ST_SCAN = 3'b010;
  localparam ST_PAD = 3'b100;

  // two-flop synchronisers, one per pin; only the second flop is read
  localparam NPIN = 5;
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] sync_b;
  assign pin_raw = {keep_relay, keep_valid, reset_pin, stop_pin, power_ok};
  wire pwr_s = sync_b[0];
  wire stop_s = sync_b[1];
  wire rst_s = sync_b[2];
  wire kvalid_s = sync_b[3];
  wire krelay_s = sync_b[4];

  // reset to 0: power reads absent until two clean samples
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      reg meta;
      reg stable;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= pin_raw[gi];
          stable <= meta;
        end
      end
      assign sync_b[gi] = stable;
    end
  endgenerate

  // registers
  reg [`RSC_CTRL_W-1:0] ctrl;
  reg [NCLS-1:0] backup_keep;
  reg [31:0] wdt_preset;
  reg [31:0] scan_period;
  reg wdt_to;
  reg keep_err;
  reg [2:0] state;
  reg [1:0] boot_cnt;
  reg [31:0] wdt_cnt;
  reg [31:0] period_cnt;

  wire relay = ctrl[`RSC_CTRL_RELAY];
  wire hold_outputs_flag = ctrl[`RSC_CTRL_HOLD];
  wire stop_en = ctrl[`RSC_CTRL_STOP_EN];
  wire rst_en = ctrl[`RSC_CTRL_RST_EN];
  wire pwr_en = ctrl[`RSC_CTRL_PWR_EN];
  wire pwr_run = ctrl[`RSC_CTRL_PWR_RUN];
  wire keep_err_run = ctrl[`RSC_CTRL_KEEP_ERR_RUN];
  wire wdt_en = ctrl[`RSC_CTRL_WDT_EN];

  // apb decode; zero wait states
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == `RSC_OFF_CTRL);
  wire hit_backup = (paddr == `RSC_OFF_BACKUP);
  wire hit_wdt = (paddr == `RSC_OFF_WDT);
  wire hit_scan = (paddr == `RSC_OFF_SCAN);
  wire hit_stat = (paddr == `RSC_OFF_STATUS);
  wire mapped = hit_ctrl | hit_backup | hit_wdt | hit_scan | hit_stat;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // stop sources; stop always beats run
  // any one stop source is enough; running needs all of them clear
  reg relay_run;
  reg stop_req;
  reg next_running;
  always @* begin
    if (stop_en)
      relay_run = ~stop_s;
    else
      relay_run = relay;
    stop_req = 1'b0;
    if (!pwr_s)
      stop_req = 1'b1;
    if (wdt_to)
      stop_req = 1'b1;
    if (rst_en && rst_s)
      stop_req = 1'b1;
    if (stop_en && stop_s)
      stop_req = 1'b1;
    if (!stop_en && !relay)
      stop_req = 1'b1;
    next_running = ~stop_req & relay_run;
  end
  wire scan_end = (state == ST_SCAN) & scan_done;
  wire pending = (next_running != running);

  // control register, including the retained relay
  wire boot_load = (state == ST_BOOT) && (boot_cnt == 2'h0);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `RSC_CTRL_RESET;
      keep_err <= 1'b0;
    end else begin
      if (boot_load) begin
        // relay restored once the synchronised store value is stable;
        // a host write to ctrl in this one cycle is lost entirely
        // power-up select beats the store, the store beats keep-error
        keep_err <= ~kvalid_s;
        if (pwr_en)
          ctrl[`RSC_CTRL_RELAY] <= pwr_run;
        else if (kvalid_s)
          ctrl[`RSC_CTRL_RELAY] <= krelay_s;
        else
          ctrl[`RSC_CTRL_RELAY] <= keep_err_run;
      end else if (wr && hit_ctrl) begin
        ctrl <= pwdata[`RSC_CTRL_W-1:0];
      end
    end
  end

  // memory keep mask, one bit per class
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      backup_keep <= `RSC_BACKUP_RESET;
    else if (wr && hit_backup)
      backup_keep <= pwdata[NCLS-1:0];
  end

  // watchdog preset in clock cycles
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      wdt_preset <= `RSC_WDT_RESET;
    else if (wr && hit_wdt)
      wdt_preset <= pwdata;
  end

  // constant scan period; zero turns padding off
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      scan_period <= `RSC_SCAN_RESET;
    else if (wr && hit_scan)
      scan_period <= pwdata;
  end

  // retained store always mirrors the relay
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      relay_store <= 1'b0;
    else
      relay_store <= relay;
  end

  // scan sequencer: boot, scan, pad to constant period
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_BOOT;
      boot_cnt <= `RSC_STARTUP_CYCLES;
      scan_go <= 1'b0;
      period_cnt <= 32'h00000000;
    end else begin
      scan_go <= 1'b0;
      if (period_cnt != 32'hffffffff)
        period_cnt <= period_cnt + 32'h00000001;
      case (state)
        ST_BOOT: begin
          if (boot_cnt != 2'h0) begin
            boot_cnt <= boot_cnt - 2'h1;
          end else begin
            state <= ST_SCAN;
            scan_go <= 1'b1;
            period_cnt <= 32'h00000001;
          end
        end
        ST_SCAN: begin
          if (scan_done)
            state <= ST_PAD;
        end
        ST_PAD: begin
          // zero period: next scan starts right away
          if (period_cnt >= scan_period) begin
            state <= ST_SCAN;
            scan_go <= 1'b1;
            period_cnt <= 32'h00000001;
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  // watchdog counts only inside a scan; a hung scan never reaches its end
  // the counter saturates rather than wraps, so a stuck scan stays caught
  wire wdt_hit = wdt_en & (state == ST_SCAN) & ~scan_done
    & (wdt_cnt >= wdt_preset);
  wire wdt_clr = wr & hit_stat & pwdata[`RSC_STAT_WDT_TO];
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt <= 32'h00000000;
      wdt_to <= 1'b0;
    end else begin
      if (state != ST_SCAN || scan_done)
        wdt_cnt <= 32'h00000000;
      else if (wdt_cnt != 32'hffffffff)
        wdt_cnt <= wdt_cnt + 32'h00000001;
      // set beats a clear in the same cycle
      if (wdt_hit)
        wdt_to <= 1'b1;
      else if (wdt_clr)
        wdt_to <= 1'b0;
    end
  end

  // run state and the side effects at end of scan; outputs_clear also follows the hold flag while stopped
  reg next_run_state;
  reg next_periph_halt;
  reg next_outputs_clear;
  reg next_timer_reset;
  reg [NCLS-1:0] next_mem_clear;
  always @* begin
    // stop sources were merged above; only the commit happens here
    next_run_state = running;
    next_periph_halt = periph_halt;
    next_outputs_clear = outputs_clear;
    next_timer_reset = 1'b0;
    next_mem_clear = {NCLS{1'b0}};
    if (scan_end) begin
      next_run_state = next_running;
      next_periph_halt = ~next_running;
      next_outputs_clear = ~next_running & ~hold_outputs_flag;
      if (running && !next_running)
        next_timer_reset = 1'b1;
      if (!running && next_running)
        next_mem_clear = ~backup_keep;
      // reset input wins over the keep mask
      if (rst_en && rst_s)
        next_mem_clear = {NCLS{1'b1}};
    end else if (!running) begin
      // flag may change while stopped
      next_outputs_clear = ~hold_outputs_flag;
    end
  end

  // every side-effect output leaves a flop
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      running <= 1'b0;
      periph_halt <= 1'b1;
      outputs_clear <= 1'b1;
      timer_reset <= 1'b0;
      mem_clear <= {NCLS{1'b0}};
    end else begin
      running <= next_run_state;
      periph_halt <= next_periph_halt;
      outputs_clear <= next_outputs_clear;
      timer_reset <= next_timer_reset;
      mem_clear <= next_mem_clear;
    end
  end

  // read mux; unmapped reads give zero
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (hit_ctrl)
      rd_word[`RSC_CTRL_W-1:0] = ctrl;
    else if (hit_backup)
      rd_word[NCLS-1:0] = backup_keep;
    else if (hit_wdt)
      rd_word = wdt_preset;
    else if (hit_scan)
      rd_word = scan_period;
    else if (hit_stat) begin
      rd_word[`RSC_STAT_RUNNING] = running;
      rd_word[`RSC_STAT_PENDING] = pending;
      rd_word[`RSC_STAT_WDT_TO] = wdt_to;
      rd_word[`RSC_STAT_KEEP_ERR] = keep_err;
      rd_word[`RSC_STAT_STOP_IN] = stop_s;
      rd_word[`RSC_STAT_RESET_IN] = rst_s;
    end
  end

  // read data leaves a flop: captured in the setup cycle so the zero-wait
  // access phase shows a settled word; status is thus one cycle old
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= rd_word;
  end

endmodule // rsc_run_stop

// >>> hw/rsc_consts.vh
// constants for the run/stop supervisor: register map, fields, reset values
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

`define RSC_ADDR_W 8
`define RSC_OFF_CTRL 8'h00
`define RSC_OFF_BACKUP 8'h04
`define RSC_OFF_WDT 8'h08
`define RSC_OFF_SCAN 8'h0c
`define RSC_OFF_STATUS 8'h10

`define RSC_CTRL_RELAY 0
`define RSC_CTRL_HOLD 1
`define RSC_CTRL_STOP_EN 2
`define RSC_CTRL_RST_EN 3
`define RSC_CTRL_PWR_EN 4
`define RSC_CTRL_PWR_RUN 5
`define RSC_CTRL_KEEP_ERR_RUN 6
`define RSC_CTRL_WDT_EN 7
`define RSC_CTRL_W 8
`define RSC_CTRL_RESET 8'h80

`define RSC_STAT_RUNNING 0
`define RSC_STAT_PENDING 1
`define RSC_STAT_WDT_TO 2
`define RSC_STAT_KEEP_ERR 3
`define RSC_STAT_STOP_IN 4
`define RSC_STAT_RESET_IN 5

`define RSC_MEM_CLASSES 4
`define RSC_BACKUP_RESET 4'hf
`define RSC_WDT_RESET 32'h000f4240
`define RSC_SCAN_RESET 32'h00000000
`define RSC_STARTUP_CYCLES 2'h3

`endif

// >>> sim/rsc_scan_model.sv
// scan engine model: answers each scan start with an end-of-scan pulse
`timescale 1ns/1ps
module rsc_scan_model #(parameter int DLY = 3) (
  input logic mclk,
  input logic nrst,
  input logic scan_go,
  output logic scan_done
);
  int cnt;
  // done comes strictly after go, never in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      scan_done <= 1'b0;
    end else begin
      scan_done <= (cnt == 1);
      if (scan_go) cnt <= DLY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // rsc_scan_model

// >>> sim/rsc_run_stop_monitor.sv
// port checker for the run/stop supervisor
`timescale 1ns/1ps
module rsc_run_stop_monitor #(parameter NCLS = 4) (
  input logic mclk, nrst, psel, penable, pwrite, pready, pslverr,
  input logic [7:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic power_ok, stop_pin, reset_pin, keep_valid, keep_relay,
  input logic scan_done, scan_go, running, periph_halt, outputs_clear,
  input logic timer_reset, relay_store,
  input logic [NCLS-1:0] mem_clear
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_halt_level: assert property (periph_halt == !running)
    else $error("halt differs from stop");
  chk_run_end: assert property ($changed(running) |-> $past(scan_done))
    else $error("run change off scan end");
  chk_timer_fall: assert property ($fell(running) |-> timer_reset)
    else $error("no timer reset on stop");
  chk_timer_only: assert property (timer_reset |-> $fell(running))
    else $error("stray timer reset");
  chk_clear_stop: assert property (outputs_clear |-> !running)
    else $error("outputs cleared while running");
  chk_go_pulse: assert property (scan_go |=> !scan_go)
    else $error("scan start too long");
  // power sync takes two flops, so four low cycles are settled
  chk_power_stop: assert property (
    !power_ok [*4] ##0 scan_done |=> !running)
    else $error("run without power");
  chk_mem_end: assert property (|mem_clear |-> $past(scan_done))
    else $error("memory clear off scan end");
  chk_relay_keep: assert property (
    psel && penable && pwrite && paddr == 8'h00
    |-> ##2 relay_store == $past(pwdata[0], 2))
    else $error("relay not stored");
endmodule // rsc_run_stop_monitor

bind rsc_run_stop rsc_run_stop_monitor #(.NCLS(NCLS)) u_mon (.*);

// >>> sim/tb_rsc_run_stop.sv
// self-checking bench for the run/stop supervisor
`timescale 1ns/1ps
`include "rsc_consts.vh"
module tb_rsc_run_stop;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic power_ok = 1, stop_pin = 0, reset_pin = 0, keep_valid = 1;
  logic keep_relay = 1, scan_done, scan_go, running, periph_halt, se;
  logic outputs_clear, timer_reset, relay_store, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0] mem_clear, mc;
  int errors = 0, checks = 0;
  rsc_run_stop i_dut (.*);
  rsc_scan_model i_scan (.*);
  initial forever #2 mclk = ~mclk;
  task automatic cmp(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  // gathers memory clear pulses while waiting
  task automatic pass(input int n);
    repeat (n) begin
      @(posedge mclk);
      mc |= mem_clear;
    end
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 100 && running !== v; i++) pass(1);
  endtask
  task automatic t_regs;
    bus(`RSC_OFF_BACKUP, 0, 0); cmp(q, `RSC_BACKUP_RESET);
    bus(`RSC_OFF_WDT, 0, 0); cmp(q, `RSC_WDT_RESET);
    bus(8'h40, 0, 0); cmp(se, 1);
    wait_run(1); cmp(running, 1);
    bus(`RSC_OFF_CTRL, 0, 0); cmp(q, 32'h81);
    $display("regs done");
  endtask
  task automatic t_relay;
    bus(0, 1, 32'h80); wait_run(0); cmp(running, 0);
    cmp({periph_halt, outputs_clear}, 2'b11);
    bus(0, 1, 32'h82); @(posedge mclk); cmp(outputs_clear, 0);
    bus(0, 1, 32'h83); wait_run(1); cmp(running, 1);
    $display("relay done");
  endtask
  task automatic t_stop_in;
    bus(0, 1, 32'h85);
    stop_pin <= 1; wait_run(0); cmp(running, 0);
    bus(0, 1, 32'h84); stop_pin <= 0; wait_run(1); cmp(running, 1);
    bus(0, 1, 32'h81);
    $display("stop input done");
  endtask
  task automatic t_reset_in;
    bus(0, 1, 32'h89); mc = 0;
    reset_pin <= 1; wait_run(0); pass(12); cmp(running, 0);
    cmp(mc, 4'hf);
    reset_pin <= 0; bus(0, 1, 32'h81); wait_run(1); cmp(running, 1);
    $display("reset input done");
  endtask
  task automatic t_power;
    power_ok <= 0; wait_run(0); cmp(running, 0);
    power_ok <= 1; wait_run(1); cmp(running, 1);
    $display("power done");
  endtask
  task automatic t_backup;
    bus(`RSC_OFF_BACKUP, 1, 32'h5); bus(0, 1, 32'h80); wait_run(0);
    mc = 0; bus(0, 1, 32'h81); wait_run(1); cmp(mc, 4'ha);
    $display("backup done");
  endtask
  task automatic t_wdt;
    bus(`RSC_OFF_WDT, 1, 2); wait_run(0); cmp(running, 0);
    bus(`RSC_OFF_STATUS, 0, 0); cmp(q[`RSC_STAT_WDT_TO], 1);
    bus(`RSC_OFF_WDT, 1, 32'h20); bus(`RSC_OFF_STATUS, 1, 4);
    bus(`RSC_OFF_STATUS, 0, 0); cmp(q[`RSC_STAT_WDT_TO], 0);
    wait_run(1); cmp(running, 1);
    $display("watchdog done");
  endtask
  task automatic t_period;
    int n;
    bus(`RSC_OFF_SCAN, 1, 20);
    n = 0;
    do @(posedge mclk); while (scan_go !== 1'b1);
    do begin
      @(posedge mclk);
      n++;
    end while (scan_go !== 1'b1 && n < 100);
    cmp(n, 20);
    bus(`RSC_OFF_SCAN, 1, 0);
    $display("period done");
  endtask
  task automatic t_boot;
    keep_valid <= 0; nrst <= 0;
    repeat (4) @(posedge mclk);
    nrst <= 1; pass(30); cmp(running, 0);
    bus(`RSC_OFF_STATUS, 0, 0); cmp(q[`RSC_STAT_KEEP_ERR], 1);
    bus(`RSC_OFF_CTRL, 0, 0); cmp(q, 32'h80);
    keep_valid <= 1; bus(0, 1, 32'h81); wait_run(1); cmp(running, 1);
    $display("boot done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1;
    t_regs; t_relay; t_stop_in; t_reset_in; t_power; t_backup;
    t_wdt; t_period; t_boot;
    conclude;
  end
endmodule // tb_rsc_run_stop
